// >>> rtl/osc_pkg.sv
// constants, register layouts and types for the oscillator and pll control block
package osc_pkg;
	localparam logic [11:0] internal_osc_control_addr = 12'h000;
	localparam logic [11:0] crystal_osc_control_addr = 12'h004;
	localparam logic [11:0] pll_control_addr = 12'h008;
	localparam logic [11:0] irq_status_addr = 12'h00c;
	localparam logic [11:0] irq_mask_addr = 12'h010;
	localparam logic [11:0] clock_source_addr = 12'h014;
	// internal_osc_control fields
	localparam int auto_trim_enable_bit = 7;
	localparam int trim_done_flag_bit = 6;
	localparam int trim_fix_enable_bit = 5;
	localparam int rc_osc_stable_flag_bit = 1;
	localparam int rc_osc_enable_bit = 0;
	// crystal_osc_control fields
	localparam int crystal_range_select_bit = 2;
	localparam int crystal_stable_flag_bit = 1;
	localparam int crystal_enable_bit = 0;
	// pll_control fields
	localparam int reserved_top_bit_pos = 7;
	localparam int pll_input_select_bit = 5;
	localparam int pll_output_select_lsb = 2;
	localparam int pll_stable_flag_bit = 1;
	localparam int pll_enable_bit = 0;
	// clock_source field
	localparam int high_source_select_bit = 0;
	// interrupt status layout
	localparam int irq_rc_stable_bit = 0;
	localparam int irq_crystal_stable_bit = 1;
	localparam int irq_pll_stable_bit = 2;
	localparam int irq_trim_done_bit = 3;
	localparam int irq_width = 4;
	// reset values
	localparam logic rc_osc_enable_rst = 1'b1;
	localparam logic pll_enable_rst = 1'b1;
	localparam logic [2:0] pll_output_select_rst = 3'h0;
	localparam logic high_source_select_rst = 1'b0;
	// pll output select codes
	localparam logic [2:0] pll_out_6mhz = 3'h4;
	localparam logic [2:0] pll_out_12mhz = 3'h5;
	localparam logic [2:0] pll_out_16mhz = 3'h6;
	localparam logic [2:0] pll_out_reserved = 3'h7;
	// ten megahertz crystal range boundary in khz
	localparam int crystal_range_limit_khz = 10000;
	localparam int pll_multiply = 8;
	localparam int pll_halve = 2;
	// timing in pclk cycles at 125 MHz
	localparam int clk_period_ns = 8;
	localparam int rc_settle_ns = 2000;
	localparam int crystal_settle_ns = 8000;
	localparam int pll_settle_ns = 4000;
	localparam int trim_settle_ns = 16000;
	localparam int rc_settle_cycles = (rc_settle_ns + clk_period_ns - 1) / clk_period_ns;
	localparam int crystal_settle_cycles = (crystal_settle_ns + clk_period_ns - 1) / clk_period_ns;
	localparam int pll_settle_cycles = (pll_settle_ns + clk_period_ns - 1) / clk_period_ns;
	localparam int trim_settle_cycles = (trim_settle_ns + clk_period_ns - 1) / clk_period_ns;
	// pll reference path
	typedef enum logic [2:0] {
		path_off = 3'b001,
		path_halve_mult = 3'b010,
		path_mult = 3'b100
	} pll_path_type;
	typedef struct packed {
		logic pll_active;
		logic [1:0] pre_divide;
		logic [3:0] multiply;
		logic use_pll_output;
		logic [2:0] output_code;
	} pll_route_type;
	typedef struct packed {
		logic trim_done;
		logic pll_stable;
		logic crystal_stable;
		logic rc_stable;
	} osc_events_type;
endpackage

// >>> rtl/settle_counter.sv
// counts enabled cycles and raises a stable level once the count is reached
`timescale 1ns/1ps
module settle_counter #(
	parameter int cycles = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic enable,
	output logic stable,
	output logic rise
);
	localparam int cnt_w = $clog2(cycles + 1);
	localparam logic [cnt_w-1:0] cnt_last = cnt_w'(cycles);
	logic [cnt_w-1:0] count_q, count_d;
	logic stable_q, stable_d;

	always_comb begin
		count_d = count_q;
		stable_d = stable_q;
		if (!enable) begin
			count_d = '0;
			stable_d = 1'b0;
		end else if (!stable_q) begin
			if (count_q == cnt_last - cnt_w'(1)) begin
				stable_d = 1'b1;
			end
			count_d = count_q + cnt_w'(1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_q <= '0;
			stable_q <= 1'b0;
		end else begin
			count_q <= count_d;
			stable_q <= stable_d;
		end
	end

	assign stable = stable_q;
	assign rise = stable_d & ~stable_q;
endmodule

// >>> rtl/pll_route.sv
// decodes pll reference path and output routing from the control fields
`timescale 1ns/1ps
module pll_route (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pll_enable,
	input wire logic pll_input_select,
	input wire logic high_source_select,
	input wire logic [2:0] pll_output_select,
	output osc_pkg::pll_route_type route,
	output osc_pkg::pll_path_type path
);
	import osc_pkg::*;
	pll_route_type route_q, route_d;
	pll_path_type path_q, path_d;

	always_comb begin
		route_d = '0;
		path_d = path_off;
		route_d.pll_active = pll_enable;
		route_d.output_code = pll_output_select;
		// top bit low routes the plain oscillator; 111 is reserved and keeps it too
		route_d.use_pll_output = pll_output_select[2] && (pll_output_select != pll_out_reserved);
		if (pll_enable) begin
			// rc source is always 12 MHz, so it takes the halving path
			if (!pll_input_select || !high_source_select) begin
				path_d = path_halve_mult;
				route_d.pre_divide = 2'(pll_halve);
			end else begin
				path_d = path_mult;
				route_d.pre_divide = 2'd1;
			end
			route_d.multiply = 4'(pll_multiply);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			route_q <= '0;
			path_q <= path_off;
		end else begin
			route_q <= route_d;
			path_q <= path_d;
		end
	end

	assign route = route_q;
	assign path = path_q;
endmodule

// >>> rtl/osc_pll_control.sv
// oscillator, crystal and pll control registers with stable flags, trimming and interrupts
`timescale 1ns/1ps
module osc_pll_control #(
	parameter int rc_cycles = osc_pkg::rc_settle_cycles,
	parameter int crystal_cycles = osc_pkg::crystal_settle_cycles,
	parameter int pll_cycles = osc_pkg::pll_settle_cycles,
	parameter int trim_cycles = osc_pkg::trim_settle_cycles
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic usb_mode,
	input wire logic crystal_pins_active,
	output logic rc_osc_on,
	output logic crystal_on,
	output logic crystal_high_range,
	output logic trim_active,
	output osc_pkg::pll_route_type pll_route_out,
	output osc_pkg::pll_path_type pll_path_out,
	output logic irq
);
	import osc_pkg::*;

	logic usb_mode_s1_q, usb_mode_s2_q;
	logic pins_s1_q, pins_s2_q;

	logic auto_trim_enable_q, auto_trim_enable_d;
	logic trim_done_flag_q, trim_done_flag_d;
	logic trim_fix_enable_q, trim_fix_enable_d;
	logic rc_osc_enable_q, rc_osc_enable_d;
	logic crystal_range_select_q, crystal_range_select_d;
	logic crystal_enable_q, crystal_enable_d;
	logic reserved_top_bit_q, reserved_top_bit_d;
	logic pll_input_select_q, pll_input_select_d;
	logic [2:0] pll_output_select_q, pll_output_select_d;
	logic pll_enable_q, pll_enable_d;
	logic high_source_select_q, high_source_select_d;
	logic [irq_width-1:0] irq_status_q, irq_status_d;
	logic [irq_width-1:0] irq_mask_q, irq_mask_d;
	logic [31:0] prdata_q, prdata_d;

	logic rc_stable, rc_rise;
	logic crystal_stable, crystal_rise;
	logic pll_stable, pll_rise;
	logic trim_settled, trim_rise;
	logic wr, rd, lane0, mapped;
	logic [7:0] wbyte;
	osc_events_type ev;

	// pins from outside the pclk domain pass two flip-flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			usb_mode_s1_q <= 1'b0;
			usb_mode_s2_q <= 1'b0;
			pins_s1_q <= 1'b0;
			pins_s2_q <= 1'b0;
		end else begin
			usb_mode_s1_q <= usb_mode;
			usb_mode_s2_q <= usb_mode_s1_q;
			pins_s1_q <= crystal_pins_active;
			pins_s2_q <= pins_s1_q;
		end
	end

	settle_counter #(.cycles(rc_cycles)) u_rc_settle (
		.pclk(pclk),
		.presetn(presetn),
		.enable(rc_osc_enable_q),
		.stable(rc_stable),
		.rise(rc_rise)
	);

	settle_counter #(.cycles(crystal_cycles)) u_crystal_settle (
		.pclk(pclk),
		.presetn(presetn),
		.enable(crystal_enable_q),
		.stable(crystal_stable),
		.rise(crystal_rise)
	);

	settle_counter #(.cycles(pll_cycles)) u_pll_settle (
		.pclk(pclk),
		.presetn(presetn),
		.enable(pll_enable_q),
		.stable(pll_stable),
		.rise(pll_rise)
	);

	// trimming only runs with a running rc oscillator in usb mode
	assign trim_active = auto_trim_enable_q & usb_mode_s2_q & rc_stable;

	settle_counter #(.cycles(trim_cycles)) u_trim_settle (
		.pclk(pclk),
		.presetn(presetn),
		.enable(trim_active),
		.stable(trim_settled),
		.rise(trim_rise)
	);

	pll_route u_pll_route (
		.pclk(pclk),
		.presetn(presetn),
		.pll_enable(pll_enable_q),
		.pll_input_select(pll_input_select_q),
		.high_source_select(high_source_select_q),
		.pll_output_select(pll_output_select_q),
		.route(pll_route_out),
		.path(pll_path_out)
	);

	assign wr = psel & penable & pwrite;
	assign rd = psel & ~penable & ~pwrite;
	assign lane0 = pstrb[0];
	assign wbyte = pwdata[7:0];
	assign mapped = (paddr == internal_osc_control_addr) || (paddr == crystal_osc_control_addr) ||
		(paddr == pll_control_addr) || (paddr == irq_status_addr) ||
		(paddr == irq_mask_addr) || (paddr == clock_source_addr);

	always_comb begin
		ev.rc_stable = rc_rise;
		ev.crystal_stable = crystal_rise;
		ev.pll_stable = pll_rise;
		ev.trim_done = trim_rise;
	end

	always_comb begin
		auto_trim_enable_d = auto_trim_enable_q;
		trim_done_flag_d = trim_done_flag_q;
		trim_fix_enable_d = trim_fix_enable_q;
		rc_osc_enable_d = rc_osc_enable_q;
		crystal_range_select_d = crystal_range_select_q;
		crystal_enable_d = crystal_enable_q;
		reserved_top_bit_d = reserved_top_bit_q;
		pll_input_select_d = pll_input_select_q;
		pll_output_select_d = pll_output_select_q;
		pll_enable_d = pll_enable_q;
		high_source_select_d = high_source_select_q;
		irq_status_d = irq_status_q;
		irq_mask_d = irq_mask_q;
		if (wr && lane0) begin
			case (paddr)
				internal_osc_control_addr: begin
					auto_trim_enable_d = wbyte[auto_trim_enable_bit];
					// writing zero clears; writing one leaves it alone
					if (!wbyte[trim_done_flag_bit]) begin
						trim_done_flag_d = 1'b0;
					end
					trim_fix_enable_d = wbyte[trim_fix_enable_bit];
					rc_osc_enable_d = wbyte[rc_osc_enable_bit];
				end
				crystal_osc_control_addr: begin
					// range is frozen while the crystal runs on active pins
					if (!(crystal_enable_q && pins_s2_q)) begin
						crystal_range_select_d = wbyte[crystal_range_select_bit];
					end
					crystal_enable_d = wbyte[crystal_enable_bit];
				end
				pll_control_addr: begin
					reserved_top_bit_d = wbyte[reserved_top_bit_pos];
					pll_input_select_d = wbyte[pll_input_select_bit];
					pll_output_select_d = wbyte[pll_output_select_lsb +: 3];
					pll_enable_d = wbyte[pll_enable_bit];
				end
				irq_status_addr: begin
					irq_status_d = irq_status_q & ~wbyte[irq_width-1:0];
				end
				irq_mask_addr: begin
					irq_mask_d = wbyte[irq_width-1:0];
				end
				clock_source_addr: begin
					high_source_select_d = wbyte[high_source_select_bit];
				end
				default: begin
				end
			endcase
		end
		// flag sets when trimming settles and clears when trimming stops; hardware set wins over a clear
		if (!auto_trim_enable_d || !trim_active) begin
			trim_done_flag_d = 1'b0;
		end else if (trim_rise) begin
			trim_done_flag_d = 1'b1;
		end
		if (!high_source_select_d) begin
			pll_input_select_d = 1'b0;
		end
		irq_status_d = irq_status_d | ev;
	end

	always_comb begin
		prdata_d = prdata_q;
		if (rd) begin
			prdata_d = '0;
			case (paddr)
				internal_osc_control_addr: begin
					prdata_d[auto_trim_enable_bit] = auto_trim_enable_q;
					prdata_d[trim_done_flag_bit] = trim_done_flag_q;
					prdata_d[trim_fix_enable_bit] = trim_fix_enable_q;
					prdata_d[rc_osc_stable_flag_bit] = rc_stable;
					prdata_d[rc_osc_enable_bit] = rc_osc_enable_q;
				end
				crystal_osc_control_addr: begin
					prdata_d[crystal_range_select_bit] = crystal_range_select_q;
					prdata_d[crystal_stable_flag_bit] = crystal_stable;
					prdata_d[crystal_enable_bit] = crystal_enable_q;
				end
				pll_control_addr: begin
					prdata_d[reserved_top_bit_pos] = reserved_top_bit_q;
					prdata_d[pll_input_select_bit] = pll_input_select_q;
					prdata_d[pll_output_select_lsb +: 3] = pll_output_select_q;
					prdata_d[pll_stable_flag_bit] = pll_stable;
					prdata_d[pll_enable_bit] = pll_enable_q;
				end
				irq_status_addr: begin
					prdata_d[irq_width-1:0] = irq_status_q;
				end
				irq_mask_addr: begin
					prdata_d[irq_width-1:0] = irq_mask_q;
				end
				clock_source_addr: begin
					prdata_d[high_source_select_bit] = high_source_select_q;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			auto_trim_enable_q <= 1'b0;
			trim_done_flag_q <= 1'b0;
			trim_fix_enable_q <= 1'b0;
			rc_osc_enable_q <= rc_osc_enable_rst;
			crystal_range_select_q <= 1'b0;
			crystal_enable_q <= 1'b0;
			reserved_top_bit_q <= 1'b0;
			pll_input_select_q <= 1'b0;
			pll_output_select_q <= pll_output_select_rst;
			pll_enable_q <= pll_enable_rst;
			high_source_select_q <= high_source_select_rst;
			irq_status_q <= '0;
			irq_mask_q <= '0;
			prdata_q <= '0;
		end else begin
			auto_trim_enable_q <= auto_trim_enable_d;
			trim_done_flag_q <= trim_done_flag_d;
			trim_fix_enable_q <= trim_fix_enable_d;
			rc_osc_enable_q <= rc_osc_enable_d;
			crystal_range_select_q <= crystal_range_select_d;
			crystal_enable_q <= crystal_enable_d;
			reserved_top_bit_q <= reserved_top_bit_d;
			pll_input_select_q <= pll_input_select_d;
			pll_output_select_q <= pll_output_select_d;
			pll_enable_q <= pll_enable_d;
			high_source_select_q <= high_source_select_d;
			irq_status_q <= irq_status_d;
			irq_mask_q <= irq_mask_d;
			prdata_q <= prdata_d;
		end
	end

	// no wait states: every access completes in its first access cycle
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign prdata = prdata_q;
	assign rc_osc_on = rc_osc_enable_q;
	assign crystal_on = crystal_enable_q;
	assign crystal_high_range = crystal_range_select_q;
	assign irq = |(irq_status_q & irq_mask_q);
endmodule

// >>> tb/osc_pll_control_asserts.sv
// concurrent checks on the oscillator and pll control block ports
`timescale 1ns/1ps
module osc_pll_control_asserts (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic crystal_pins_active,
	input wire logic crystal_on,
	input wire logic crystal_high_range,
	input wire osc_pkg::pll_route_type pll_route_out,
	input wire osc_pkg::pll_path_type pll_path_out
);
	import osc_pkg::*;
	logic rd_acc;
	logic mapped;
	logic xtal_wr;
	assign rd_acc = psel && penable && !pwrite;
	assign mapped = paddr inside {internal_osc_control_addr, crystal_osc_control_addr, pll_control_addr,
		irq_status_addr, irq_mask_addr, clock_source_addr};
	assign xtal_wr = psel && penable && pwrite && pstrb[0] && paddr == crystal_osc_control_addr && pwdata[0];
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// synchronised pin level is only trusted after several raw cycles
	sequence pins_held;
		crystal_pins_active [*4];
	endsequence
	ready_always_a: assert property (pready)
		else $error("pready dropped");
	unmapped_err_a: assert property (psel && penable |-> pslverr == !mapped)
		else $error("pslverr disagrees with address map");
	upper_zero_a: assert property (rd_acc |-> prdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	xtal_unused_a: assert property (rd_acc && paddr == crystal_osc_control_addr |-> prdata[7:3] == 5'h0)
		else $error("crystal unused bits not zero");
	pll_bit6_a: assert property (rd_acc && paddr == pll_control_addr |-> !prdata[6])
		else $error("pll bit six not zero");
	output_route_a: assert property (pll_route_out.use_pll_output == (pll_route_out.output_code[2] &&
		pll_route_out.output_code != pll_out_reserved))
		else $error("output routing wrong for code");
	path_mult_a: assert property (pll_path_out != path_off |-> pll_route_out.pll_active &&
		pll_route_out.multiply == 4'(pll_multiply))
		else $error("active path without times eight");
	halve_div_a: assert property (pll_path_out == path_halve_mult |-> pll_route_out.pre_divide == 2'(pll_halve))
		else $error("halve path without divide by two");
	range_hold_a: assert property (pins_held ##0 (crystal_on && $past(crystal_on)) |-> $stable(crystal_high_range))
		else $error("range changed while crystal running");
	xtal_cause_a: assert property ($rose(crystal_on) |-> $past(xtal_wr) || $past(xtal_wr, 2))
		else $error("crystal started without enable write");
endmodule
bind osc_pll_control osc_pll_control_asserts osc_pll_control_asserts_i (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .crystal_pins_active(crystal_pins_active),
	.crystal_on(crystal_on), .crystal_high_range(crystal_high_range), .pll_route_out(pll_route_out),
	.pll_path_out(pll_path_out));

// >>> tb/osc_pll_control_tb.sv
// self-checking bench for the oscillator and pll control block
`timescale 1ns/1ps
module osc_pll_control_tb;
	import osc_pkg::*;
	localparam int rc_n = 8;
	localparam int xt_n = 12;
	localparam int pl_n = 10;
	localparam int tr_n = 16;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hf;
	logic usb_mode = 1'b0;
	logic crystal_pins_active = 1'b0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err, rc_osc_on, crystal_on, crystal_high_range, trim_active, irq;
	pll_route_type route;
	pll_path_type path;
	logic [15:0] lfsr = 16'ha89a;
	int bad_count = 0;
	int n_compared = 0;
	always #4 pclk = ~pclk;
	osc_pll_control #(.rc_cycles(rc_n), .crystal_cycles(xt_n), .pll_cycles(pl_n), .trim_cycles(tr_n))
		osc_pll_control_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.usb_mode(usb_mode), .crystal_pins_active(crystal_pins_active), .rc_osc_on(rc_osc_on),
		.crystal_on(crystal_on), .crystal_high_range(crystal_high_range), .trim_active(trim_active),
		.pll_route_out(route), .pll_path_out(path), .irq(irq));
	function automatic logic [15:0] next_rand(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic exp_use(input logic [2:0] c);
		return c[2] && c != pll_out_reserved;
	endfunction
	// rc source always goes through the halving path
	function automatic pll_path_type exp_path(input logic is, input logic src);
		return (is && src) ? path_mult : path_halve_mult;
	endfunction
	task automatic give_verdict();
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input string what);
		apb(1'b0, a, 32'h0);
		cmp(what, exp, rd);
	endtask
	initial begin
		repeat (20000) @(posedge pclk);
		bad_count++;
		$display("unexpected hang: watchdog expired");
		give_verdict();
	end
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		crystal_pins_active <= 1'b1;
		repeat (pl_n + 6) @(posedge pclk);
		rchk(internal_osc_control_addr, 32'h3, "rc ctl");
		rchk(crystal_osc_control_addr, 32'h0, "xtal ctl");
		rchk(pll_control_addr, 32'h3, "pll ctl");
		rchk(irq_status_addr, 32'h5, "irq status");
		rchk(clock_source_addr, 32'h0, "clk src");
		apb(1'b0, 12'h018, 32'h0);
		cmp("slverr", 32'h1, 32'(err));
		$display("reset test done");
		for (int i = 0; i < 6; i++) begin
			lfsr = next_rand(lfsr);
			apb(1'b1, crystal_osc_control_addr, {lfsr, lfsr} & 32'hfffffffe);
			rchk(crystal_osc_control_addr, {29'h0, lfsr[2], 2'b0}, "xtal ctl");
			cmp("range", 32'(lfsr[2]), 32'(crystal_high_range));
		end
		apb(1'b1, irq_mask_addr, 32'h2);
		apb(1'b1, irq_status_addr, 32'hf);
		apb(1'b1, crystal_osc_control_addr, 32'h4);
		apb(1'b1, crystal_osc_control_addr, 32'h5);
		rchk(crystal_osc_control_addr, 32'h5, "xtal unsettled");
		cmp("irq", 32'h0, 32'(irq));
		repeat (xt_n + 6) @(posedge pclk);
		rchk(crystal_osc_control_addr, 32'h7, "xtal settled");
		cmp("irq", 32'h1, 32'(irq));
		apb(1'b1, crystal_osc_control_addr, 32'h1);
		rchk(crystal_osc_control_addr, 32'h7, "xtal range held");
		apb(1'b1, irq_mask_addr, 32'h0);
		rchk(irq_mask_addr, 32'h0, "irq mask");
		cmp("irq", 32'h0, 32'(irq));
		apb(1'b1, irq_mask_addr, 32'h2);
		rchk(irq_status_addr, 32'h2, "irq status");
		cmp("irq", 32'h1, 32'(irq));
		apb(1'b1, irq_status_addr, 32'h2);
		rchk(irq_status_addr, 32'h0, "irq status");
		cmp("irq", 32'h0, 32'(irq));
		apb(1'b1, crystal_osc_control_addr, 32'h0);
		rchk(crystal_osc_control_addr, 32'h4, "xtal off");
		cmp("xtal on", 32'h0, 32'(crystal_on));
		// range is only frozen while the pins are active as well
		crystal_pins_active <= 1'b0;
		apb(1'b1, crystal_osc_control_addr, 32'h5);
		apb(1'b1, crystal_osc_control_addr, 32'h1);
		rchk(crystal_osc_control_addr, 32'h1, "xtal range free");
		cmp("range", 32'h0, 32'(crystal_high_range));
		apb(1'b1, crystal_osc_control_addr, 32'h0);
		crystal_pins_active <= 1'b1;
		$display("crystal test done");
		apb(1'b1, pll_control_addr, 32'h7d);
		rchk(pll_control_addr, 32'h1f, "pll ctl");
		cmp("pll use", 32'h0, 32'(route.use_pll_output));
		cmp("path", 32'(path_halve_mult), 32'(path));
		apb(1'b1, clock_source_addr, 32'h1);
		for (int i = 0; i < 16; i++) begin
			apb(1'b1, pll_control_addr, {26'h0, i[3], i[2:0], 2'b01});
			repeat (2) @(posedge pclk);
			cmp("path", 32'(exp_path(i[3], 1'b1)), 32'(path));
			cmp("pll div", i[3] ? 32'h1 : 32'(pll_halve), 32'(route.pre_divide));
			cmp("pll mult", 32'(pll_multiply), 32'(route.multiply));
			cmp("pll active", 32'h1, 32'(route.pll_active));
			cmp("pll use", 32'(exp_use(i[2:0])), 32'(route.use_pll_output));
			cmp("pll code", 32'(i[2:0]), 32'(route.output_code));
		end
		apb(1'b1, pll_control_addr, 32'h0);
		repeat (2) @(posedge pclk);
		cmp("path", 32'(path_off), 32'(path));
		cmp("pll active", 32'h0, 32'(route.pll_active));
		apb(1'b1, pll_control_addr, 32'h1);
		rchk(pll_control_addr, 32'h1, "pll unsettled");
		repeat (pl_n + 6) @(posedge pclk);
		rchk(pll_control_addr, 32'h3, "pll settled");
		$display("pll test done");
		apb(1'b1, internal_osc_control_addr, 32'h0);
		rchk(internal_osc_control_addr, 32'h0, "rc off");
		cmp("rc on", 32'h0, 32'(rc_osc_on));
		apb(1'b1, internal_osc_control_addr, 32'h1);
		rchk(internal_osc_control_addr, 32'h1, "rc unsettled");
		usb_mode <= 1'b1;
		repeat (rc_n + 6) @(posedge pclk);
		rchk(internal_osc_control_addr, 32'h3, "rc settled");
		apb(1'b1, clock_source_addr, 32'h0);
		apb(1'b1, internal_osc_control_addr, 32'h81);
		repeat (4) @(posedge pclk);
		cmp("trim active", 32'h1, 32'(trim_active));
		rchk(internal_osc_control_addr, 32'h83, "trim unsettled");
		repeat (tr_n + 6) @(posedge pclk);
		rchk(internal_osc_control_addr, 32'hc3, "trim settled");
		apb(1'b1, internal_osc_control_addr, 32'h81);
		rchk(internal_osc_control_addr, 32'h83, "trim cleared");
		apb(1'b1, internal_osc_control_addr, 32'h01);
		rchk(internal_osc_control_addr, 32'h03, "trim off");
		cmp("trim active", 32'h0, 32'(trim_active));
		rchk(irq_status_addr, 32'hd, "irq events");
		// trimming must stay off outside usb mode
		usb_mode <= 1'b0;
		apb(1'b1, internal_osc_control_addr, 32'h81);
		repeat (4) @(posedge pclk);
		cmp("trim no usb", 32'h0, 32'(trim_active));
		$display("trim test done");
		give_verdict();
	end
endmodule
